// file: rtl/sac_pkg.sv
package sac_pkg;
   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int RES_W = 10;
   localparam int CHAN_W = 4;
   localparam int REF_W = 2;
   localparam int CNT_W = 5;
   localparam int DIV_W = 5;

   // ------------------------------------------------------------
   // Clock rates and converter clock divider
   // ------------------------------------------------------------
   localparam int REF_CLK_KHZ = 10000;
   localparam int CONV_CLK_KHZ = 200;
   localparam int DIV_HALF = REF_CLK_KHZ / (2 * CONV_CLK_KHZ);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_HALF - 1);
   localparam logic [DIV_W-1:0] DIV_ZERO = 5'h00;

   // ------------------------------------------------------------
   // Conversion timing, in converter clock cycles
   // ------------------------------------------------------------
   localparam int NORM_CYCLES = 13;
   localparam int EXT_CYCLES = 25;
   localparam logic [CNT_W-1:0] NORM_LAST = CNT_W'(NORM_CYCLES - 1);
   localparam logic [CNT_W-1:0] EXT_LAST = CNT_W'(EXT_CYCLES - 1);
   // Hold falls half a cycle after these rising edges (1.5 / 13.5)
   localparam logic [CNT_W-1:0] NORM_HOLD = 5'h01;
   localparam logic [CNT_W-1:0] EXT_HOLD = 5'h0d;
   localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;

   // ------------------------------------------------------------
   // Codes and reset values
   // ------------------------------------------------------------
   localparam logic [RES_W-1:0] SAR_MSB = 10'h200;
   localparam logic [RES_W-1:0] RES_ZERO = 10'h000;
   localparam logic [3:0] SAR_TOP_BIT = 4'h9;
   localparam logic [REF_W-1:0] REF_EXTERNAL = 2'h0;
   localparam logic [REF_W-1:0] REF_SUPPLY = 2'h1;
   localparam logic [REF_W-1:0] REF_INTERNAL = 2'h3;
   localparam logic [CHAN_W-1:0] CHAN_BANDGAP = 4'he;
   localparam logic [CHAN_W-1:0] CHAN_GROUND = 4'hf;

   typedef enum logic [1:0] {
      SAC_IDLE = 2'b01,
      SAC_CONV = 2'b10
   } sac_state_e;
endpackage : sac_pkg

// file: rtl/sac_conv_ctrl.sv
// Functional notes
// RULE1: The input is converted by successive approximation to a 10-bit code.
// RULE2: Reference select picks external, analog supply or internal 2.56V.
// RULE3: Channel select picks one of eight pins, analog ground or bandgap.
// RULE4: A free-run select bit chooses single or free-running conversion.
// RULE5: Setting the start bit starts a conversion at the next converter edge.
// RULE6: Converter clock runs while enabled and is held in reset otherwise.
// RULE7: A normal conversion completes in 13 converter clock cycles.
// RULE8: The first conversion after enabling is extended to 25 cycles.
// RULE9: Sample-and-hold is 1.5 cycles (normal) or 13.5 (extended) in.
// RULE10: On completion the result is stored and the complete flag set.
// RULE11: In single mode the start bit clears as the result is stored.
// RULE12: In free-running mode a new conversion follows, start bit stays high.
// RULE13: Software should discard the first result after changing selection.
// RULE14: An extended conversion ends exactly like a normal one.
`timescale 1ns/10ps
`default_nettype none
module sac_conv_ctrl
   import sac_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic enable_i,
   input wire logic free_run_i,
   input wire logic start_set_i,
   input wire logic flag_clr_i,
   input wire logic [REF_W-1:0] ref_sel_i,
   input wire logic [CHAN_W-1:0] chan_sel_i,
   input wire logic comp_i,
   output logic start_bit_o,
   output logic done_flag_o,
   output logic [RES_W-1:0] result_o,
   output logic [RES_W-1:0] trial_code_o,
   output logic hold_o,
   output logic ref_ext_o,
   output logic ref_supply_o,
   output logic ref_internal_o,
   output logic [7:0] chan_pin_o,
   output logic chan_bandgap_o,
   output logic chan_ground_o
);

   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   function automatic logic [9:0] chan_decode(input logic [CHAN_W-1:0] s);
      logic [9:0] d;
      d = 10'h000;
      if (s[3] == 1'b0) begin
         d[s[2:0]] = 1'b1;
      end else if (s == CHAN_BANDGAP) begin
         d[8] = 1'b1;
      end else begin
         // Unused codes fall back to ground, a harmless input
         d[9] = 1'b1;
      end
      return d;
   endfunction

   // ------------------------------------------------------------
   // Reference and channel steering
   // ------------------------------------------------------------
   logic [9:0] chan_dec;
   assign chan_dec = chan_decode(chan_sel_i);

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ref_ext_o <= 1'b1;
         ref_supply_o <= 1'b0;
         ref_internal_o <= 1'b0;
      end else begin
         ref_supply_o <= (ref_sel_i == REF_SUPPLY); // RULE2
         ref_internal_o <= (ref_sel_i == REF_INTERNAL); // RULE2
         ref_ext_o <= (ref_sel_i != REF_SUPPLY) && (ref_sel_i != REF_INTERNAL);
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         chan_pin_o <= 8'h00;
         chan_bandgap_o <= 1'b0;
         chan_ground_o <= 1'b1;
      end else begin
         chan_pin_o <= chan_dec[7:0]; // RULE3
         chan_bandgap_o <= chan_dec[8]; // RULE3
         chan_ground_o <= chan_dec[9];
      end
   end

   // ------------------------------------------------------------
   // Comparator synchroniser
   // ------------------------------------------------------------
   logic comp_meta;
   logic comp_sync;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         comp_meta <= 1'b0;
         comp_sync <= 1'b0;
      end else begin
         comp_meta <= comp_i;
         comp_sync <= comp_meta;
      end
   end

   // ------------------------------------------------------------
   // Converter clock divider
   // ------------------------------------------------------------
   logic [DIV_W-1:0] div_cnt;
   logic div_phase;
   logic div_wrap;
   logic rise_tick;
   logic fall_tick;

   assign div_wrap = enable_i && (div_cnt == DIV_LAST);
   assign rise_tick = div_wrap && !div_phase;
   assign fall_tick = div_wrap && div_phase;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i || !enable_i) begin
         div_cnt <= DIV_ZERO; // RULE6
         div_phase <= 1'b0;
      end else if (div_wrap) begin
         div_cnt <= DIV_ZERO;
         div_phase <= !div_phase;
      end else begin
         div_cnt <= div_cnt + 5'h01;
      end
   end

   // ------------------------------------------------------------
   // Conversion sequencer
   // ------------------------------------------------------------
   sac_state_e state;
   logic [CNT_W-1:0] cyc_cnt;
   logic ext_pending;
   logic ext_active;
   logic [RES_W-1:0] sar;
   logic [3:0] bit_ptr;
   logic begin_conv;
   logic done;
   logic decide;
   logic [CNT_W-1:0] hold_at;

   assign hold_at = ext_active ? EXT_HOLD : NORM_HOLD; // RULE9
   assign begin_conv = rise_tick && (state == SAC_IDLE) && start_bit_o;
   assign done = rise_tick && (state == SAC_CONV) &&
      (cyc_cnt == (ext_active ? EXT_LAST : NORM_LAST)); // RULE7 RULE8 RULE14
   assign decide = rise_tick && (state == SAC_CONV) && !done &&
      (cyc_cnt > hold_at) && (cyc_cnt <= hold_at + 5'h0a);
   assign trial_code_o = sar;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i || !enable_i) begin
         state <= SAC_IDLE;
         cyc_cnt <= CNT_ZERO;
      end else begin
         case (state)
            SAC_IDLE: begin
               if (begin_conv) begin
                  state <= SAC_CONV; // RULE5
                  cyc_cnt <= CNT_ZERO;
               end
            end
            SAC_CONV: begin
               if (done) begin
                  // Free run restarts on the same edge
                  state <= free_run_i ? SAC_CONV : SAC_IDLE; // RULE12
                  cyc_cnt <= CNT_ZERO;
               end else if (rise_tick) begin
                  cyc_cnt <= cyc_cnt + 5'h01;
               end
            end
            default: begin
               state <= SAC_IDLE;
               cyc_cnt <= CNT_ZERO;
            end
         endcase
      end
   end

   // First conversion after enabling is the long one
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || !enable_i) begin
         ext_pending <= 1'b1;
         ext_active <= 1'b0;
      end else if (begin_conv) begin
         ext_active <= ext_pending; // RULE8
         ext_pending <= 1'b0;
      end else if (done) begin
         ext_active <= 1'b0;
      end
   end

   // Sample-and-hold and binary search
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || !enable_i) begin
         hold_o <= 1'b0;
         sar <= RES_ZERO;
         bit_ptr <= SAR_TOP_BIT;
      end else if (fall_tick && state == SAC_CONV && cyc_cnt == hold_at) begin
         hold_o <= 1'b1; // RULE9
         sar <= SAR_MSB;
         bit_ptr <= SAR_TOP_BIT;
      end else if (decide) begin
         // Comparator high: input at or above trial, keep the bit
         if (!comp_sync) begin
            sar[bit_ptr] <= 1'b0; // RULE1
         end
         if (bit_ptr != 4'h0) begin
            sar[bit_ptr - 4'h1] <= 1'b1;
            bit_ptr <= bit_ptr - 4'h1;
         end
      end else if (done) begin
         hold_o <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Software-visible bits
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         start_bit_o <= 1'b0;
      end else if (start_set_i) begin
         start_bit_o <= 1'b1; // Set wins over completion clear
      end else if (!enable_i) begin
         start_bit_o <= 1'b0;
      end else if (done && !free_run_i) begin
         start_bit_o <= 1'b0; // RULE11 RULE4
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         done_flag_o <= 1'b0;
      end else if (done) begin
         done_flag_o <= 1'b1; // RULE10
      end else if (flag_clr_i) begin
         done_flag_o <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         result_o <= RES_ZERO;
      end else if (done) begin
         result_o <= sar; // RULE10
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   AST_SINGLE_CLEAR: assert property ( // RULE11
      done && !free_run_i && !start_set_i |=> !start_bit_o)
      else $error("start bit not cleared at single completion");
   AST_FLAG_SET: assert property ( // RULE10
      done |=> done_flag_o)
      else $error("complete flag not set");
   AST_RESULT: assert property ( // RULE10
      done |=> result_o == $past(sar))
      else $error("result not stored");
   AST_NORMAL_LEN: assert property ( // RULE7
      done && !ext_active |-> cyc_cnt == NORM_LAST)
      else $error("normal conversion length wrong");
   AST_EXT_LEN: assert property ( // RULE8
      done && ext_active |-> cyc_cnt == EXT_LAST)
      else $error("extended conversion length wrong");
   AST_FREE_RUN: assert property ( // RULE12
      done && free_run_i && enable_i |=> state == SAC_CONV && start_bit_o)
      else $error("free run did not restart");
   AST_DIV_RESET: assert property ( // RULE6
      !enable_i |=> div_cnt == DIV_ZERO && state == SAC_IDLE)
      else $error("divider not held while disabled");
   AST_HOLD_TIME: assert property ( // RULE9
      $rose(hold_o) |-> $past(fall_tick) && $past(cyc_cnt) == $past(hold_at))
      else $error("hold at wrong time");
   AST_START_EDGE: assert property ( // RULE5
      begin_conv && enable_i |=> state == SAC_CONV && cyc_cnt == CNT_ZERO)
      else $error("conversion did not start on edge");
   logic conv_seen;
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || !enable_i) begin
         conv_seen <= 1'b0;
      end else if (begin_conv) begin
         conv_seen <= 1'b1;
      end
   end
   AST_FIRST_EXT: assert property ( // RULE8
      begin_conv && !conv_seen |=> ext_active)
      else $error("first conversion not extended");

endmodule // sac_conv_ctrl
`default_nettype wire

// file: dv/sac_analog_model.sv
`timescale 1ns/10ps
`default_nettype none
module sac_analog_model
   import sac_pkg::*;
#(
   parameter logic [RES_W-1:0] BG_CODE = 10'h138
)(
   input wire logic ref_clk_i,
   input wire logic [7:0] chan_pin_i,
   input wire logic chan_bandgap_i,
   input wire logic chan_ground_i,
   input wire logic hold_i,
   input wire logic [RES_W-1:0] trial_code_i,
   input wire logic [7:0][RES_W-1:0] pin_level_i,
   output logic comp_o
);
   logic [RES_W-1:0] live;
   logic [RES_W-1:0] held;
   always_comb begin
      live = RES_ZERO;
      for (int k = 0; k < 8; k++) begin
         if (chan_pin_i[k]) begin
            live = pin_level_i[k];
         end
      end
      if (chan_bandgap_i) begin
         live = BG_CODE;
      end
      if (chan_ground_i) begin
         live = RES_ZERO;
      end
   end
   // Tracks until hold, then frozen for the bit decisions
   always_ff @(posedge ref_clk_i) begin
      if (!hold_i) begin
         held <= live;
      end
   end
   assign comp_o = (held >= trial_code_i);
endmodule // sac_analog_model
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   import sac_pkg::*;
   localparam logic [RES_W-1:0] BG = 10'h138;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic enable = 1'b0;
   logic free_run = 1'b0;
   logic start_set = 1'b0;
   logic flag_clr = 1'b0;
   logic [REF_W-1:0] ref_sel = 2'h0;
   logic [CHAN_W-1:0] chan_sel = 4'hf;
   logic [7:0][RES_W-1:0] lvl = '0;
   logic comp, start_bit, done_flag, hold, ref_ext, ref_supply;
   logic ref_internal, chan_bandgap, chan_ground, flag_q;
   logic [RES_W-1:0] result;
   logic [RES_W-1:0] trial;
   logic [RES_W-1:0] exp_r;
   logic [7:0] chan_pin;
   logic [RES_W-1:0] exp_q[$];
   int err_total = 0;
   int total_checks = 0;
   int seed = 386;
   initial forever #50 clk = ~clk;
   sac_conv_ctrl sac_conv_ctrl_i (.ref_clk_i(clk), .rst_i(rst),
      .enable_i(enable), .free_run_i(free_run), .start_set_i(start_set),
      .flag_clr_i(flag_clr), .ref_sel_i(ref_sel), .chan_sel_i(chan_sel),
      .comp_i(comp), .start_bit_o(start_bit), .done_flag_o(done_flag),
      .result_o(result), .trial_code_o(trial), .hold_o(hold),
      .ref_ext_o(ref_ext), .ref_supply_o(ref_supply),
      .ref_internal_o(ref_internal), .chan_pin_o(chan_pin),
      .chan_bandgap_o(chan_bandgap), .chan_ground_o(chan_ground));
   sac_analog_model #(.BG_CODE(BG)) sac_analog_model_i (.ref_clk_i(clk),
      .chan_pin_i(chan_pin), .chan_bandgap_i(chan_bandgap),
      .chan_ground_i(chan_ground), .hold_i(hold),
      .trial_code_i(trial), .pin_level_i(lvl),
      .comp_o(comp));
   // ------------------------------------------------------------
   // Checking
   // ------------------------------------------------------------
   task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_res(input logic [9:0] got, input logic [9:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t result=%h exp=%h", $time, got, exp);
      end
   endtask
   // Empty queue forces a miss: a completion nobody asked for
   always @(negedge clk) begin
      flag_q <= done_flag;
      if (done_flag === 1'b1 && flag_q !== 1'b1) begin
         exp_r = exp_q.size() ? exp_q.pop_front() : ~result;
         cmp_res(result, exp_r);
      end
   end
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // Stimulus
   // ------------------------------------------------------------
   task automatic conv(input logic [3:0] ch, input int reps, output int n,
                       output int hl);
      logic [9:0] v;
      v = 10'($random(seed));
      // Ideal model settles at once, so the first result is kept
      @(posedge clk) chan_sel <= ch;
      lvl[ch[2:0]] <= v;
      repeat (reps) exp_q.push_back(ch < 8 ? v : ch == 4'he ? BG : 10'h000);
      @(posedge clk) start_set <= 1'b1;
      @(posedge clk) start_set <= 1'b0;
      for (int k = 0; k < reps; k++) begin
         n = 0;
         hl = -1;
         do begin
            @(negedge clk);
            n++;
            if (hold === 1'b1 && hl < 0) hl = n;
         end while (done_flag !== 1'b1 && n < 3000);
         cmp_val(start_bit, free_run);
         @(posedge clk) flag_clr <= 1'b1;
         @(posedge clk) flag_clr <= 1'b0;
      end
   endtask
   initial begin
      #3000000;
      err_total++;
      $display("watchdog expired");
      tally_and_finish();
   end
   initial begin
      int n;
      int hl;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      cmp_val({start_bit, done_flag, result, ref_ext, chan_ground},
         16'h0003);
      for (int r = 0; r < 4; r++) begin
         @(posedge clk) ref_sel <= r[1:0];
         repeat (2) @(negedge clk);
         cmp_val({ref_internal, ref_supply, ref_ext},
            r == 3 ? 3'h4 : r == 1 ? 3'h2 : 3'h1);
      end
      for (int c = 0; c < 16; c++) begin
         @(posedge clk) chan_sel <= c[3:0];
         repeat (2) @(negedge clk);
         cmp_val({chan_ground, chan_bandgap, chan_pin},
            c < 8 ? 10'h1 << c : c == 14 ? 10'h100 : 10'h200);
      end
      $display("test selection done");
      @(posedge clk) enable <= 1'b1;
      repeat (3) @(posedge clk);
      conv(4'h3, 1, n, hl);
      cmp_val(16'(n >= 1250 && n <= 1330), 16'h1);
      cmp_val(16'(n - hl), 16'd575);
      for (int k = 0; k < 6; k++) begin
         conv(k < 4 ? 4'($random(seed) & 7) : k == 4 ? 4'he : 4'hf, 1, n, hl);
         cmp_val(16'(n >= 650 && n <= 710), 16'h1);
         cmp_val(16'(n - hl), 16'd575);
      end
      $display("test single done");
      @(posedge clk) free_run <= 1'b1;
      conv(4'h6, 3, n, hl);
      @(posedge clk) enable <= 1'b0;
      free_run <= 1'b0;
      repeat (2) @(negedge clk);
      cmp_val(start_bit, 16'h0);
      $display("test free run done");
      @(posedge clk) start_set <= 1'b1;
      @(posedge clk) start_set <= 1'b0;
      repeat (3) @(negedge clk);
      cmp_val({start_bit, done_flag}, 16'h0);
      @(posedge clk) enable <= 1'b1;
      repeat (3) @(posedge clk);
      conv(4'h0, 1, n, hl);
      cmp_val(16'(n >= 1250 && n <= 1330), 16'h1);
      cmp_val(16'(exp_q.size()), 16'h0);
      $display("test re-enable done");
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
